// file: src/qtec_top.sv
// Quad 8-bit timer / event counter with pair cascade and capture.
// Assumes clk is the oscillator reference; pins arrive asynchronously.
`timescale 1ns/1ps
module qtec_top
    import qtec_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Mode pair A/B
    input  wire logic             pair_cascade_sel_ab,
    input  wire logic             capture_sel_a,
    input  wire logic             capture_sel_b,
    input  wire logic             pwm_enable_b,
    input  wire logic [2:0]       clk_sel_a,
    input  wire logic [1:0]       clk_sel_b,
    // Mode pair C/D
    input  wire logic             pair_cascade_sel_cd,
    input  wire logic             capture_sel_c,
    input  wire logic             capture_sel_d,
    input  wire logic             pwm_enable_d,
    input  wire logic [2:0]       clk_sel_c,
    input  wire logic [1:0]       clk_sel_d,
    // Port select
    input  wire logic [7:0]       port_select_reg,
    // Match value writes
    input  wire logic             match_wr_a,
    input  wire logic             match_wr_b,
    input  wire logic             match_wr_c,
    input  wire logic             match_wr_d,
    input  wire logic [7:0]       match_wdata,
    // Flag clears
    input  wire logic             flag_clr_a,
    input  wire logic             flag_clr_b,
    input  wire logic             flag_clr_c,
    input  wire logic             flag_clr_d,
    // External pins
    input  wire logic             event_pin_a,
    input  wire logic             event_pin_c,
    input  wire logic             capture_pin_a,
    input  wire logic             capture_pin_b,
    input  wire logic             capture_pin_c,
    input  wire logic             capture_pin_d,
    // Match values
    output logic [7:0]            match_value_a,
    output logic [7:0]            match_value_b,
    output logic [7:0]            match_value_c,
    output logic [7:0]            match_value_d,
    // Counts
    output logic [7:0]            count_a,
    output logic [7:0]            count_b,
    output logic [7:0]            count_c,
    output logic [7:0]            count_d,
    // Captured values
    output logic [7:0]            captured_value_a,
    output logic [7:0]            captured_value_b,
    output logic [7:0]            captured_value_c,
    output logic [7:0]            captured_value_d,
    // Match flags
    output logic                  match_flag_a,
    output logic                  match_flag_b,
    output logic                  match_flag_c,
    output logic                  match_flag_d
);

    // ****************************************
    // Per-timer bundles
    // ****************************************
    logic [TMR_W-1:0]   match_val [NUM_TMR];
    logic [TMR_W-1:0]   count     [NUM_TMR];
    logic [TMR_W-1:0]   next_count[NUM_TMR];
    logic [TMR_W-1:0]   capt      [NUM_TMR];
    logic [TMR_W-1:0]   next_capt [NUM_TMR];
    logic               capt_load [NUM_TMR];
    logic [NUM_TMR-1:0] flag;
    logic [NUM_TMR-1:0] inc;
    logic               hit       [NUM_TMR];
    logic [NUM_TMR-1:0] cap_sel;
    logic [NUM_TMR-1:0] match_wr;
    logic [NUM_TMR-1:0] flag_clr;
    logic [1:0]         casc;
    logic [1:0]         cap16;
    logic [PRE_W-1:0]   tick;
    logic [NUM_PIN-1:0] pin_raw;
    logic [NUM_PIN-1:0] pin_rise;

    assign cap_sel  = {capture_sel_d, capture_sel_c, capture_sel_b, capture_sel_a};
    assign match_wr = {match_wr_d, match_wr_c, match_wr_b, match_wr_a};
    assign flag_clr = {flag_clr_d, flag_clr_c, flag_clr_b, flag_clr_a};
    assign pin_raw  = {event_pin_c, event_pin_a, capture_pin_d,
                       capture_pin_c, capture_pin_b, capture_pin_a};

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (PRE_W <= int'(DIV_A[6])) begin : g_bad_pre
        $error("qtec_top: prescaler too narrow for the slowest tap");
    end

    // ****************************************
    // Prescaler
    // ****************************************
    qtec_prescaler #(
        .WIDTH (PRE_W)
    ) u_pre (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick)
    );

    // ****************************************
    // Pin synchronisers
    // ****************************************
    genvar s;
    generate
        for (s = 0; s < NUM_PIN; s++) begin : g_sync
            qtec_edge_sync u_sync (
                .clk  (clk),
                .rst  (rst),
                .pin  (pin_raw[s]),
                .rise (pin_rise[s])
            );
        end
    endgenerate

    // ****************************************
    // Mode decode
    // ****************************************
    always_comb begin
        casc[0]  = pair_cascade_sel_ab & (clk_sel_b == CKSEL_CHAIN);
        casc[1]  = pair_cascade_sel_cd & (clk_sel_d == CKSEL_CHAIN);
        cap16[0] = casc[0] & capture_sel_a & capture_sel_b;
        cap16[1] = casc[1] & capture_sel_c & capture_sel_d;
    end

    // ****************************************
    // Count sources
    // ****************************************
    always_comb begin
        // Timer A: event pin or 2..2048
        if (clk_sel_a == CKSEL_EXT) begin
            inc[0] = port_select_reg[EC_EN_A_BIT] & pin_rise[PIN_EV_A];
        end else begin
            inc[0] = tick[DIV_A[clk_sel_a]];
        end
        // Timer B: 1, 2, 8 or chained
        if (clk_sel_b == CKSEL_CHAIN || pwm_enable_b) begin
            inc[1] = 1'b0;
        end else begin
            inc[1] = tick[DIV_B[clk_sel_b]];
        end
        // Timer C: event pin or 2..1024
        if (clk_sel_c == CKSEL_EXT) begin
            inc[2] = port_select_reg[EC_EN_C_BIT] & pin_rise[PIN_EV_C];
        end else begin
            inc[2] = tick[DIV_C[clk_sel_c]];
        end
        // Timer D: 1, 4, 16
        if (clk_sel_d == CKSEL_CHAIN || pwm_enable_d) begin
            inc[3] = 1'b0;
        end else begin
            inc[3] = tick[DIV_D[clk_sel_d]];
        end
    end

    // ****************************************
    // Match value registers
    // ****************************************
    genvar m;
    generate
        for (m = 0; m < NUM_TMR; m++) begin : g_match
            always_ff @(posedge clk) begin
                if (rst) begin
                    match_val[m] <= MATCH_RST;
                end else if (match_wr[m]) begin
                    match_val[m] <= match_wdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // Pair counting logic
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            localparam int LO = 2 * p;
            localparam int HI = 2 * p + 1;

            logic [2*TMR_W-1:0] cnt16;
            logic [2*TMR_W-1:0] mat16;
            logic               cap_ev16;
            logic               cap_ev_lo;
            logic               cap_ev_hi;

            assign cnt16 = {count[HI], count[LO]};
            assign mat16 = {match_val[HI], match_val[LO]};

            always_comb begin
                cap_ev16  = cap16[p] & pin_rise[LO];
                cap_ev_lo = ~casc[p] & cap_sel[LO] & pin_rise[LO];
                cap_ev_hi = ~casc[p] & cap_sel[HI] & pin_rise[HI];
                next_count[LO] = count[LO];
                next_count[HI] = count[HI];
                next_capt[LO]  = capt[LO];
                next_capt[HI]  = capt[HI];
                capt_load[LO]  = 1'b0;
                capt_load[HI]  = 1'b0;
                hit[LO]        = 1'b0;
                hit[HI]        = 1'b0;
                if (casc[p]) begin
                    if (cap_ev16) begin
                        next_capt[LO]  = count[LO];
                        next_capt[HI]  = count[HI];
                        capt_load[LO]  = 1'b1;
                        capt_load[HI]  = 1'b1;
                        next_count[LO] = COUNT_RST;
                        next_count[HI] = COUNT_RST;
                    end else if (inc[LO]) begin
                        if (cnt16 == mat16) begin
                            hit[LO]        = 1'b1;
                            next_count[LO] = COUNT_RST;
                            next_count[HI] = COUNT_RST;
                        end else begin
                            {next_count[HI], next_count[LO]} = cnt16 + 16'h0001;
                        end
                    end
                end else begin
                    if (cap_ev_lo) begin
                        next_capt[LO]  = count[LO];
                        capt_load[LO]  = 1'b1;
                        next_count[LO] = COUNT_RST;
                    end else if (inc[LO]) begin
                        if (count[LO] == match_val[LO]) begin
                            hit[LO]        = 1'b1;
                            next_count[LO] = COUNT_RST;
                        end else begin
                            next_count[LO] = count[LO] + 8'h01;
                        end
                    end
                    if (cap_ev_hi) begin
                        next_capt[HI]  = count[HI];
                        capt_load[HI]  = 1'b1;
                        next_count[HI] = COUNT_RST;
                    end else if (inc[HI]) begin
                        if (count[HI] == match_val[HI]) begin
                            hit[HI]        = 1'b1;
                            next_count[HI] = COUNT_RST;
                        end else begin
                            next_count[HI] = count[HI] + 8'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Count and capture registers
    // ****************************************
    genvar t;
    generate
        for (t = 0; t < NUM_TMR; t++) begin : g_tmr
            always_ff @(posedge clk) begin
                if (rst) begin
                    count[t] <= COUNT_RST;
                end else begin
                    count[t] <= next_count[t];
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    capt[t] <= CAPT_RST;
                end else if (capt_load[t]) begin
                    capt[t] <= next_capt[t];
                end
            end

            // Set wins over clear
            always_ff @(posedge clk) begin
                if (rst) begin
                    flag[t] <= 1'b0;
                end else if (hit[t]) begin
                    flag[t] <= 1'b1;
                end else if (flag_clr[t]) begin
                    flag[t] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Outputs
    // ****************************************
    assign match_value_a    = match_val[0];
    assign match_value_b    = match_val[1];
    assign match_value_c    = match_val[2];
    assign match_value_d    = match_val[3];
    assign count_a          = count[0];
    assign count_b          = count[1];
    assign count_c          = count[2];
    assign count_d          = count[3];
    assign captured_value_a = capt[0];
    assign captured_value_b = capt[1];
    assign captured_value_c = capt[2];
    assign captured_value_d = capt[3];
    assign match_flag_a     = flag[0];
    assign match_flag_b     = flag[1];
    assign match_flag_c     = flag[2];
    assign match_flag_d     = flag[3];

endmodule

// file: common/qtec_pkg.sv
// Shared constants of the quad timer / event counter.
// Assumes one core clock that also serves as the oscillator reference.
package qtec_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int TMR_W   = 8;
    localparam int PRE_W   = 12;
    localparam int NUM_TMR = 4;
    localparam int NUM_PIN = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] MATCH_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CAPT_RST  = 8'h00;

    // ****************************************
    // Clock select codes
    // ****************************************
    localparam logic [2:0] CKSEL_EXT   = 3'h7;
    localparam logic [1:0] CKSEL_CHAIN = 2'h3;

    // ****************************************
    // Port select bit positions
    // ****************************************
    localparam int EC_EN_A_BIT = 4;
    localparam int EC_EN_C_BIT = 5;

    // ****************************************
    // Pin slots in the synchroniser bank
    // ****************************************
    localparam int PIN_EV_A = 4;
    localparam int PIN_EV_C = 5;

    // ****************************************
    // Prescaler tap per code: ratio is 2**tap
    // ****************************************
    localparam logic [3:0] DIV_A [0:6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB};
    localparam logic [3:0] DIV_B [0:2] = '{4'h0, 4'h1, 4'h3};
    localparam logic [3:0] DIV_C [0:6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};
    localparam logic [3:0] DIV_D [0:2] = '{4'h0, 4'h2, 4'h4};

endpackage

// file: src/qtec_prescaler.sv
// Free-running prescaler with one tick per power-of-two ratio.
// Assumes tick k fires once every 2*(2**k) clocks.
`timescale 1ns/1ps
module qtec_prescaler
    import qtec_pkg::*;
#(
    parameter int WIDTH = PRE_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Ticks
    output logic [WIDTH-1:0]      tick
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("qtec_prescaler: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] pre;

    always_ff @(posedge clk) begin
        if (rst) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    // Tick k when the low k+1 bits are all ones
    genvar k;
    generate
        for (k = 0; k < WIDTH; k++) begin : g_tap
            assign tick[k] = &pre[k:0];
        end
    endgenerate

endmodule

// file: src/qtec_edge_sync.sv
// Two-stage synchroniser with a rising edge pulse.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module qtec_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin side
    input  wire logic pin,
    // Core side
    output logic      rise
);

    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // One pulse per rising edge
    assign rise = sync & ~prev;

endmodule

// file: test/qtec_asserts.sv
// Port checks for the quad timer / event counter.
// Assumes one clock domain; bound onto qtec_top below.
`timescale 1ns/1ps
module qtec_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Controls
    input wire logic       pair_cascade_sel_ab,
    input wire logic [1:0] clk_sel_b,
    input wire logic       pwm_enable_d,
    input wire logic       match_wr_a,
    input wire logic [7:0] match_wdata,
    input wire logic       flag_clr_a,
    // Status
    input wire logic [7:0] match_value_a,
    input wire logic [7:0] match_value_b,
    input wire logic [7:0] match_value_c,
    input wire logic [7:0] match_value_d,
    input wire logic [7:0] count_a,
    input wire logic [7:0] count_b,
    input wire logic [7:0] count_c,
    input wire logic       match_flag_a,
    input wire logic       match_flag_b,
    input wire logic       match_flag_c,
    input wire logic       match_flag_d
);
    default clocking cb @(posedge clk); endclocking
    // ****************************************
    // Sequences
    // ****************************************
    sequence wrap_a_s;
        (pair_cascade_sel_ab && clk_sel_b == 2'h3 && count_a == 8'hFF) ##1 (count_a == 8'h00);
    endsequence
    sequence rise_c_s;
        $rose(match_flag_c);
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    rst_clear_a: assert property (
        rst |=> (match_value_a | match_value_b | match_value_c | match_value_d) == 8'h00
            && !(match_flag_a | match_flag_b | match_flag_c | match_flag_d))
        else $error("state not cleared by reset");
    match_load_a: assert property (disable iff (rst)
        match_wr_a |=> match_value_a == $past(match_wdata))
        else $error("match value a not loaded");
    flag_zero_a: assert property (disable iff (rst)
        $rose(match_flag_a) |-> count_a == 8'h00)
        else $error("count a not cleared with flag");
    count_step_a: assert property (disable iff (rst)
        !$stable(count_a) |-> count_a == $past(count_a) + 8'h01 || count_a == 8'h00)
        else $error("count a jumped");
    match_hit_b: assert property (disable iff (rst)
        $rose(match_flag_b) |-> $past(count_b) == $past(match_value_b))
        else $error("flag b without match");
    match_hit_c: assert property (disable iff (rst)
        rise_c_s |-> $past(count_c) == $past(match_value_c))
        else $error("flag c without match");
    flag_hold_a: assert property (disable iff (rst)
        match_flag_a && !flag_clr_a |=> match_flag_a)
        else $error("flag a dropped without clear");
    pwm_idle_d: assert property (disable iff (rst)
        pwm_enable_d && !match_flag_d |=> !match_flag_d)
        else $error("timer d counted in pwm");
    carry_ab_a: assert property (disable iff (rst)
        wrap_a_s |-> count_b == $past(count_b) + 8'h01 || count_b == 8'h00)
        else $error("no carry into count b");
endmodule

bind qtec_top qtec_asserts u_chk (.clk(clk), .rst(rst), .pair_cascade_sel_ab(pair_cascade_sel_ab),
    .clk_sel_b(clk_sel_b), .pwm_enable_d(pwm_enable_d), .match_wr_a(match_wr_a), .match_wdata(match_wdata),
    .flag_clr_a(flag_clr_a), .match_value_a(match_value_a), .match_value_b(match_value_b),
    .match_value_c(match_value_c), .match_value_d(match_value_d), .count_a(count_a), .count_b(count_b),
    .count_c(count_c), .match_flag_a(match_flag_a), .match_flag_b(match_flag_b),
    .match_flag_c(match_flag_c), .match_flag_d(match_flag_d));

// file: test/qtec_pin_model.sv
// External event and capture pin source.
// Assumes requests are one-cycle pulses; each gives one rising edge.
`timescale 1ns/1ps
module qtec_pin_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Edge requests
    input  wire logic [5:0] req,
    // Pins
    output logic      [5:0] pins,
    output logic            busy
);
    logic [3:0] hold [0:5];
    // ****************************************
    // Pulse shaping: 4 high, at least 5 low
    // ****************************************
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (rst) begin
                hold[i] <= 4'h0;
            end else if (req[i] && hold[i] == 4'h0) begin
                hold[i] <= 4'h8;
            end else if (hold[i] != 4'h0) begin
                hold[i] <= hold[i] - 4'h1;
            end
        end
    end
    always_comb begin
        busy = 1'b0;
        for (int i = 0; i < 6; i++) begin
            pins[i] = hold[i] > 4'h4;
            busy = busy | (hold[i] != 4'h0);
        end
    end
endmodule

// file: test/test_quad_timer_event_counter.sv
// Self-checking bench for the quad timer / event counter.
// Assumes qtec_top, the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_quad_timer_event_counter;
    localparam int LIMIT = 80000;
    localparam int RAT [0:3][0:6] = '{'{2, 4, 8, 32, 128, 512, 2048}, '{1, 2, 8, 0, 0, 0, 0},
                                      '{2, 4, 8, 16, 64, 256, 1024}, '{1, 4, 16, 0, 0, 0, 0}};
    logic            clk, rst, casc_ab, csel_a, csel_b, pwm_d;
    logic      [2:0] ck_a, ck_c;
    logic      [1:0] ck_b, ck_d;
    logic      [7:0] psr, wdata;
    logic      [3:0] wr, clr;
    logic      [5:0] req;
    wire logic [5:0] pins;
    wire logic       busy;
    wire logic [7:0] mv [0:3];
    wire logic [7:0] cnt [0:3];
    wire logic [7:0] cap [0:3];
    wire logic [3:0] flag;
    int              err_count, n_checks, cyc;
    // ****************************************
    // Instances
    // ****************************************
    qtec_top dut (.clk(clk), .rst(rst),
        .pair_cascade_sel_ab(casc_ab), .capture_sel_a(csel_a), .capture_sel_b(csel_b),
        .pwm_enable_b(1'b0), .clk_sel_a(ck_a), .clk_sel_b(ck_b), .pair_cascade_sel_cd(1'b0),
        .capture_sel_c(1'b0), .capture_sel_d(1'b0), .pwm_enable_d(pwm_d), .clk_sel_c(ck_c),
        .clk_sel_d(ck_d), .port_select_reg(psr), .match_wr_a(wr[0]), .match_wr_b(wr[1]),
        .match_wr_c(wr[2]), .match_wr_d(wr[3]), .match_wdata(wdata), .flag_clr_a(clr[0]),
        .flag_clr_b(clr[1]), .flag_clr_c(clr[2]), .flag_clr_d(clr[3]), .event_pin_a(pins[0]),
        .event_pin_c(pins[1]), .capture_pin_a(pins[2]), .capture_pin_b(pins[3]),
        .capture_pin_c(pins[4]), .capture_pin_d(pins[5]), .match_value_a(mv[0]),
        .match_value_b(mv[1]), .match_value_c(mv[2]), .match_value_d(mv[3]), .count_a(cnt[0]),
        .count_b(cnt[1]), .count_c(cnt[2]), .count_d(cnt[3]), .captured_value_a(cap[0]),
        .captured_value_b(cap[1]), .captured_value_c(cap[2]), .captured_value_d(cap[3]),
        .match_flag_a(flag[0]), .match_flag_b(flag[1]), .match_flag_c(flag[2]), .match_flag_d(flag[3]));
    qtec_pin_model u_pins (.clk(clk), .rst(rst), .req(req), .pins(pins), .busy(busy));
    // ****************************************
    // Clock and timeout
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr_match(input int t, input logic [7:0] v);
        wdata = v;
        wr[t] = 1'b1;
        @(negedge clk);
        wr[t] = 1'b0;
    endtask
    task automatic clear_flag(input int t);
        clr[t] = 1'b1;
        @(negedge clk);
        clr[t] = 1'b0;
    endtask
    task automatic wait_flag(input int t, output int n);
        n = 0;
        while (flag[t] !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic measure(input int t, input int exp);
        int n;
        clear_flag(t);
        wait_flag(t, n);
        clear_flag(t);
        wait_flag(t, n);
        `CHK("interval", exp, n + 1)
    endtask
    task automatic set_ck(input int t, input int c);
        case (t)
            0: ck_a = 3'(c);
            1: ck_b = 2'(c);
            2: ck_c = 3'(c);
            default: ck_d = 2'(c);
        endcase
    endtask
    task automatic pulse(input int p, input int n);
        int w;
        repeat (n) begin
            req[p] = 1'b1;
            @(negedge clk);
            req[p] = 1'b0;
            w = 0;
            while (busy !== 1'b0 && w < 50) begin
                @(negedge clk);
                w++;
            end
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, casc_ab, csel_a, csel_b, pwm_d, ck_a, ck_b, ck_c, ck_d, psr, wdata, wr, clr, req} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int t = 0; t < 4; t++) begin
            `CHK("match_value", 8'h00, mv[t])
            `CHK("count", 8'h00, cnt[t])
            `CHK("captured_value", 8'h00, cap[t])
        end
        for (int t = 0; t < 4; t++) begin
            for (int c = 0; c < ((t % 2 == 1) ? 3 : 7); c++) begin
                set_ck(t, c);
                measure(t, 2 * RAT[t][c]);
            end
        end
        set_ck(0, 0);
        wr_match(0, 8'h03);
        `CHK("match_value", 8'h03, mv[0])
        measure(0, 16);
        wr_match(0, 8'h00);
        for (int k = 0; k < 2; k++) begin
            set_ck(2 * k, 7);
            wr_match(2 * k, 8'h02);
            pulse(k, 2);
            `CHK("count", 8'h00, cnt[2 * k])
            psr[4 + k] = 1'b1;
            clear_flag(2 * k);
            pulse(k, 2);
            `CHK("count", 8'h02, cnt[2 * k])
            pulse(k, 1);
            `CHK("count", 8'h00, cnt[2 * k])
            `CHK("match_flag", 1'b1, flag[2 * k])
        end
        csel_a = 1'b1;
        wr_match(0, 8'h10);
        pulse(0, 3);
        pulse(2, 1);
        `CHK("captured_value", 8'h03, cap[0])
        `CHK("count", 8'h00, cnt[0])
        csel_a = 1'b0;
        casc_ab = 1'b1;
        set_ck(1, 3);
        wr_match(0, 8'h01);
        wr_match(1, 8'h01);
        pulse(0, 257);
        `CHK("cascade count", 16'h0101, {cnt[1], cnt[0]})
        clear_flag(0);
        pulse(0, 1);
        `CHK("cascade count", 16'h0000, {cnt[1], cnt[0]})
        `CHK("match_flag", 1'b1, flag[0])
        csel_a = 1'b1;
        csel_b = 1'b1;
        pulse(0, 5);
        pulse(2, 1);
        `CHK("captured_value", 16'h0005, {cap[1], cap[0]})
        `CHK("cascade count", 16'h0000, {cnt[1], cnt[0]})
        pwm_d = 1'b1;
        clear_flag(3);
        repeat (40) @(negedge clk);
        `CHK("match_flag", 1'b0, flag[3])
        wrap_up();
    end
endmodule
